/* src/rdbc_pkg.sv */
// package for the reverse drive and braking config bank
// assumes a 32-bit axi4-lite register bus
package rdbc_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 8;
  localparam int unsigned STRB_W = DATA_W / 8;

  // register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_REV_CFG = 8'h82;
  localparam logic [IDX_W-1:0] IDX_STARTUP = 8'h84;
  localparam logic [IDX_W-1:0] IDX_STATUS  = 8'h86;

  localparam logic [DATA_W-1:0] REV_CFG_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] STARTUP_RESET = 32'h0000_0000;

  // reverse drive / braking field layout
  localparam int unsigned PARITY_BIT = 31;
  localparam int unsigned LIN_LSB    = 27;
  localparam int unsigned QUAD_LSB   = 23;
  localparam int unsigned ACCEL_W    = 4;
  localparam int unsigned CAP_LSB    = 20;
  localparam int unsigned CAP_W      = 3;
  localparam int unsigned KP_LSB     = 10;
  localparam int unsigned KI_LSB     = 0;
  localparam int unsigned GAIN_W     = 10;

  // fixed-point scale of the two loop gains
  localparam int unsigned KP_FRAC_BITS = 7;
  localparam int unsigned KI_FRAC_BITS = 9;

  // bus cap in half-ampere units
  localparam int unsigned        CAP_HALF_W    = 4;
  localparam logic [CAP_HALF_W-1:0] CAP_HALF_MIN = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [ACCEL_W-1:0] accel_lin;
    logic [ACCEL_W-1:0] accel_quad;
  } rdbc_rev_set_t;

  typedef struct packed {
    logic [CAP_W-1:0]  cap;
    logic [GAIN_W-1:0] kp;
    logic [GAIN_W-1:0] ki;
  } rdbc_brk_set_t;

  typedef struct packed {
    logic              en;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } rdbc_wr_t;

endpackage : rdbc_pkg

/* src/rdbc_axil_slave.sv */
// axi4-lite slave front end of the config bank
// assumes one clock; the bank answers reads combinationally
`timescale 1ns/1ps

module rdbc_axil_slave #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [rdbc_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [rdbc_pkg::STRB_W-1:0]   s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ADDR_W-1:0]             s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [rdbc_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output rdbc_pkg::rdbc_wr_t                 reg_wr,
  output logic [rdbc_pkg::IDX_W-1:0]         rd_idx,
  input  wire logic [rdbc_pkg::DATA_W-1:0]   rd_data
);
  import rdbc_pkg::*;

  logic              aw_full, next_aw_full, w_full, next_w_full;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr, ar_addr, next_ar_addr;
  logic [DATA_W-1:0] w_data, next_w_data, next_rdata;
  logic [STRB_W-1:0] w_strb, next_w_strb;
  logic              ar_full, next_ar_full;
  logic              next_awready, next_wready, next_arready;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic              do_write, do_read, wr_hit, rd_hit;
  logic [IDX_W-1:0]  wr_idx;

  assign wr_idx = aw_addr[IDX_W+1:2];
  assign rd_idx = ar_addr[IDX_W+1:2];
  assign wr_hit = (aw_addr[ADDR_W-1:IDX_W+2] == '0)
                  && (wr_idx == IDX_REV_CFG || wr_idx == IDX_STARTUP);
  assign rd_hit = (ar_addr[ADDR_W-1:IDX_W+2] == '0)
                  && (rd_idx == IDX_REV_CFG || rd_idx == IDX_STARTUP || rd_idx == IDX_STATUS);
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign do_read  = ar_full && !s_axi_rvalid;

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_ar_full = ar_full;
    next_ar_addr = ar_addr;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_ar_full = 1'b1;
      next_ar_addr = s_axi_araddr;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (do_read) begin
      next_ar_full = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = rd_hit ? rd_data : '0;
      next_rresp   = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = !next_aw_full;
    next_wready  = !next_w_full;
    next_arready = !next_ar_full;
    reg_wr.en    = do_write && wr_hit;
    reg_wr.idx   = wr_idx;
    reg_wr.data  = w_data;
    reg_wr.strb  = w_strb;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      w_full        <= 1'b0;
      w_data        <= '0;
      w_strb        <= '0;
      ar_full       <= 1'b0;
      ar_addr       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      aw_full       <= next_aw_full;
      aw_addr       <= next_aw_addr;
      w_full        <= next_w_full;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      ar_full       <= next_ar_full;
      ar_addr       <= next_ar_addr;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_arready <= next_arready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

endmodule : rdbc_axil_slave

/* src/rdbc_config.sv */
// reverse drive and active braking config bank, top level
// assumes synchronous operation-state inputs from the motor algorithm
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module rdbc_config #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [rdbc_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [rdbc_pkg::STRB_W-1:0]   s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [ADDR_W-1:0]             s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [rdbc_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          reverse_drive_active,
  input  wire logic                          braking_active,
  output rdbc_pkg::rdbc_rev_set_t            rev_set,
  output rdbc_pkg::rdbc_brk_set_t            brk_set,
  output logic [rdbc_pkg::CAP_HALF_W-1:0]    brake_cap_half_amps,
  output logic [rdbc_pkg::DATA_W-1:0]        startup_settings
);
  import rdbc_pkg::*;

  if (ADDR_W < IDX_W + 2 + 2 || ADDR_W > 32) begin : g_addr_check
    $error("rdbc_config: ADDR_W must lie between 12 and 32");
  end

  // ****************************************************
  // bus front end
  // ****************************************************
  rdbc_wr_t          reg_wr;
  logic [IDX_W-1:0]  rd_idx;
  logic [DATA_W-1:0] rd_data;

  rdbc_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .core_clk      (core_clk),
    .arst_n        (arst_n),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .reg_wr        (reg_wr),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data)
  );

  // ****************************************************
  // stored registers
  // ****************************************************
  logic [DATA_W-1:0] rev_cfg, next_rev_cfg;
  logic [DATA_W-1:0] next_startup;
  logic [DATA_W-1:0] wr_mask;

  // byte lanes enabled by the write strobes
  for (genvar b = 0; b < STRB_W; b++) begin : g_lane
    assign wr_mask[b*8 +: 8] = {8{reg_wr.strb[b]}};
  end

  always_comb begin
    next_rev_cfg = rev_cfg;
    next_startup = startup_settings;
    if (reg_wr.en && reg_wr.idx == IDX_REV_CFG) begin
      next_rev_cfg = (rev_cfg & ~wr_mask) | (reg_wr.data & wr_mask);
    end
    if (reg_wr.en && reg_wr.idx == IDX_STARTUP) begin
      next_startup = (startup_settings & ~wr_mask) | (reg_wr.data & wr_mask);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rev_cfg          <= REV_CFG_RESET;
      startup_settings <= STARTUP_RESET;
    end else begin
      rev_cfg          <= next_rev_cfg;
      startup_settings <= next_startup;
    end
  end

  // ****************************************************
  // field extraction
  // ****************************************************
  rdbc_rev_set_t cfg_rev;
  rdbc_brk_set_t cfg_brk;

  always_comb begin
    cfg_rev.accel_lin  = rev_cfg[LIN_LSB +: ACCEL_W];
    cfg_rev.accel_quad = rev_cfg[QUAD_LSB +: ACCEL_W];
    cfg_brk.cap        = rev_cfg[CAP_LSB +: CAP_W];
    cfg_brk.kp         = rev_cfg[KP_LSB +: GAIN_W];
    cfg_brk.ki         = rev_cfg[KI_LSB +: GAIN_W];
  end

  // ****************************************************
  // applied settings
  // ****************************************************
  logic                  rev_seen, next_rev_seen;
  logic                  brk_seen, next_brk_seen;
  rdbc_rev_set_t         next_rev_set;
  rdbc_brk_set_t         next_brk_set;
  logic [CAP_HALF_W-1:0] next_cap_half;

  always_comb begin
    next_rev_seen = reverse_drive_active;
    next_brk_seen = braking_active;
    next_rev_set  = rev_set;
    next_brk_set  = brk_set;
    next_cap_half = brake_cap_half_amps;
    // load on entry to reverse drive
    if (reverse_drive_active && !rev_seen) begin
      next_rev_set = cfg_rev;
    end
    if (braking_active && !brk_seen) begin
      next_brk_set = cfg_brk;
      // code 0 is 0.5 A, others whole amps
      if (cfg_brk.cap == '0) begin
        next_cap_half = CAP_HALF_MIN;
      end else begin
        next_cap_half = {cfg_brk.cap, 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rev_seen            <= 1'b0;
      brk_seen            <= 1'b0;
      rev_set             <= '0;
      brk_set             <= '0;
      brake_cap_half_amps <= CAP_HALF_MIN;
    end else begin
      rev_seen            <= next_rev_seen;
      brk_seen            <= next_brk_seen;
      rev_set             <= next_rev_set;
      brk_set             <= next_brk_set;
      brake_cap_half_amps <= next_cap_half;
    end
  end

  // ****************************************************
  // read mux
  // ****************************************************
  logic [3:0] status_bits;

  always_comb begin
    status_bits = {cfg_brk != brk_set, cfg_rev != rev_set, brk_seen, rev_seen};
    case (rd_idx)
      IDX_REV_CFG: rd_data = rev_cfg;
      IDX_STARTUP: rd_data = startup_settings;
      IDX_STATUS:  rd_data = DATA_W'(status_bits);
      default:     rd_data = '0;
    endcase
  end

  // ****************************************************
  // checks
  // ****************************************************
  logic started;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_rev_entry;
    !reverse_drive_active ##1 reverse_drive_active;
  endsequence

  sequence s_brk_entry;
    !braking_active ##1 braking_active;
  endsequence

  chk_reset_values: assert property (
    !started |-> rev_cfg == REV_CFG_RESET && startup_settings == STARTUP_RESET)
    else $error("registers not zero after reset");

  chk_cfg_write: assert property (
    reg_wr.en && reg_wr.idx == IDX_REV_CFG && (&reg_wr.strb)
    |=> rev_cfg == $past(reg_wr.data) && $stable(startup_settings))
    else $error("config word write lost");

  chk_startup_write: assert property (
    reg_wr.en && reg_wr.idx == IDX_STARTUP && (&reg_wr.strb)
    |=> startup_settings == $past(reg_wr.data) && $stable(rev_cfg))
    else $error("startup word write lost");

  chk_lin_apply: assert property (
    s_rev_entry |=> rev_set.accel_lin == $past(rev_cfg[LIN_LSB +: ACCEL_W]))
    else $error("linear acceleration not applied");

  chk_quad_apply: assert property (
    s_rev_entry |=> rev_set.accel_quad == $past(rev_cfg[QUAD_LSB +: ACCEL_W]))
    else $error("quadratic acceleration not applied");

  chk_cap_decode: assert property (
    s_brk_entry |=> brake_cap_half_amps
      == ($past(rev_cfg[CAP_LSB +: CAP_W]) == '0 ? CAP_HALF_MIN
          : {$past(rev_cfg[CAP_LSB +: CAP_W]), 1'b0}))
    else $error("bus cap decode wrong");

  chk_gain_apply: assert property (
    s_brk_entry |=> brk_set.kp == $past(rev_cfg[KP_LSB +: GAIN_W])
                    && brk_set.ki == $past(rev_cfg[KI_LSB +: GAIN_W]))
    else $error("braking gains not applied");

  chk_rev_hold: assert property (
    reverse_drive_active [*2] |=> $stable(rev_set))
    else $error("reverse settings changed mid-operation");

  chk_brk_hold: assert property (
    braking_active [*2] |=> $stable(brk_set) && $stable(brake_cap_half_amps))
    else $error("brake settings changed mid-operation");

endmodule : rdbc_config

/* testbench/testbench.sv */
// self-checking bench for the reverse drive and braking config bank
// assumes rdbc_pkg and rdbc_config compiled first; master drives on rising edges
`timescale 1ns/1ps

module testbench;
  import rdbc_pkg::*;

  logic                      core_clk;
  logic                      arst_n;
  logic [11:0]               s_axi_awaddr;
  logic                      s_axi_awvalid;
  logic                      s_axi_awready;
  logic [31:0]               s_axi_wdata;
  logic [3:0]                s_axi_wstrb;
  logic                      s_axi_wvalid;
  logic                      s_axi_wready;
  logic [1:0]                s_axi_bresp;
  logic                      s_axi_bvalid;
  logic                      s_axi_bready;
  logic [11:0]               s_axi_araddr;
  logic                      s_axi_arvalid;
  logic                      s_axi_arready;
  logic [31:0]               s_axi_rdata;
  logic [1:0]                s_axi_rresp;
  logic                      s_axi_rvalid;
  logic                      s_axi_rready;
  logic                      reverse_drive_active;
  logic                      braking_active;
  rdbc_rev_set_t             rev_set;
  rdbc_brk_set_t             brk_set;
  logic [CAP_HALF_W-1:0]     brake_cap_half_amps;
  logic [31:0]               startup_settings;
  logic [31:0]               cfg;
  logic [31:0]               old_cfg;
  int                        errors;
  int                        checks_done;

  rdbc_config i_dut (
    .core_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .reverse_drive_active, .braking_active, .rev_set, .brk_set, .brake_cap_half_amps, .startup_settings
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ****************************************
  // compare and closing
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // bus master
  // ****************************************
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_pend;
    logic w_pend;
    int   n;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_pend || w_pend) begin
      @(posedge core_clk);
      n++;
      if (aw_pend && s_axi_awready === 1'b1) begin
        aw_pend = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_pend && s_axi_wready === 1'b1) begin
        w_pend = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    // answer seen two edges after the take
    check("write cycles", 32'(n), 32'h0000_0003);
    check("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("read cycles", 32'(n), 32'h0000_0003);
    check("rdata", s_axi_rdata, ed);
    check("rresp", 32'(s_axi_rresp), 32'(er));
  endtask : axi_read

  // ****************************************
  // operation entries
  // ****************************************
  task automatic leave_ops();
    @(posedge core_clk);
    reverse_drive_active <= 1'b0;
    braking_active <= 1'b0;
    @(posedge core_clk);
  endtask : leave_ops

  task automatic enter_ops(input logic rev, input logic brk);
    @(posedge core_clk);
    reverse_drive_active <= rev;
    braking_active <= brk;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : enter_ops

  task automatic check_applied(input logic [31:0] rc, input logic [31:0] bc);
    check("rev_set", 32'(rev_set), 32'(rc[30:23]));
    check("brk_set", 32'(brk_set), 32'(bc[22:0]));
    check("cap_half", 32'(brake_cap_half_amps), (bc[22:20] == 3'h0) ? 32'h0000_0001 : 32'(bc[22:20]) * 2);
  endtask : check_applied

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    errors = 0;
    checks_done = 0;
    arst_n = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    reverse_drive_active = 1'b0;
    braking_active = 1'b0;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check_applied(32'h0000_0000, 32'h0000_0000);
    check("startup out", startup_settings, 32'h0000_0000);
    axi_read(12'h208, 32'h0000_0000, RESP_OKAY);
    axi_read(12'h210, 32'h0000_0000, RESP_OKAY);
    // every code of the acceleration and cap fields, sixteen values of each gain, readback and applied
    for (int i = 0; i < 16; i++) begin
      cfg = {1'(i), 4'(i), 4'(15 - i), 3'(i), 10'(i * 67), 10'(1023 - i * 61)};
      axi_write(12'h208, cfg, 4'hF, RESP_OKAY);
      axi_read(12'h208, cfg, RESP_OKAY);
      leave_ops();
      enter_ops(1'b1, 1'b1);
      check_applied(cfg, cfg);
    end
    // write during operation is held back until the next entry
    old_cfg = cfg;
    cfg = 32'h5A5A_5A5A;
    axi_write(12'h208, cfg, 4'hF, RESP_OKAY);
    check_applied(old_cfg, old_cfg);
    axi_read(12'h20B, cfg, RESP_OKAY);
    // status: both pending, both operations seen
    axi_read(12'h218, 32'h0000_000F, RESP_OKAY);
    leave_ops();
    check_applied(old_cfg, old_cfg);
    enter_ops(1'b0, 1'b1);
    check_applied(old_cfg, cfg);
    leave_ops();
    enter_ops(1'b1, 1'b0);
    check_applied(cfg, cfg);
    // startup word with byte lanes
    axi_write(12'h210, 32'h1234_5678, 4'hF, RESP_OKAY);
    axi_write(12'h210, 32'hFFFF_FFFF, 4'h5, RESP_OKAY);
    axi_read(12'h210, 32'h12FF_56FF, RESP_OKAY);
    check("startup out", startup_settings, 32'h12FF_56FF);
    // refused accesses leave the bank untouched
    axi_write(12'h300, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    axi_read(12'h300, 32'h0000_0000, RESP_SLVERR);
    axi_write(12'h218, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    axi_write(12'hA08, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    axi_read(12'h208, cfg, RESP_OKAY);
    axi_read(12'h210, 32'h12FF_56FF, RESP_OKAY);
    // status: nothing pending, only reverse drive seen
    axi_read(12'h218, 32'h0000_0001, RESP_OKAY);
    // reset in mid-run clears the written bank
    leave_ops();
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check_applied(32'h0000_0000, 32'h0000_0000);
    check("startup out", startup_settings, 32'h0000_0000);
    axi_read(12'h208, 32'h0000_0000, RESP_OKAY);
    axi_read(12'h210, 32'h0000_0000, RESP_OKAY);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    complete_run();
  end

endmodule : testbench
